/* File: hw/pci_config_pm_capability.sv */
// configuration space bank: cap pointer, interrupt, scratch, signature, pm
//
// Notes on behaviour
// RULE_01 - bits 31:24 of 3ch give read-only max latency, 250 ns units
// RULE_02 - bits 23:16 of 3ch give read-only min grant, 250 ns units
// RULE_03 - both timing bytes load from eeprom at power-on or hardware reset
// RULE_04 - interrupt pin field always reads 01h, meaning INTA#
// RULE_05 - firmware writes interrupt line field; device keeps it read-write
// RULE_06 - scratch byte 15:8 at 40h is read-write, survives software reset
// RULE_07 - wake support field 31:27 reads 11111b
// RULE_08 - state two and state one support flags read 1
// RULE_09 - aux current field 24:22 reads 010b
// RULE_10 - special initialisation flag bit 21 reads 0
// RULE_11 - wake clock flag bit 19 reads 0
// RULE_12 - pm version field 18:16 reads 010b
// RULE_13 - next item pointer reads 00h, ending the list
// RULE_14 - capability identifier reads 01h
// RULE_15 - signature holds device id 31:16 and vendor id 15:0, read-only
// RULE_16 - capabilities pointer constant addresses the pm capability
// RULE_17 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`include "pci_cfg_pm_cfg.svh"
module pci_config_pm_capability #(
    // identity codes: arbitrary neutral values
    parameter logic [15:0] DEVICE_ID = 16'h0abc,
    parameter logic [15:0] VENDOR_ID = 16'h0def
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic soft_rst,
    input wire logic eeprom_valid,
    input wire pci_cfg_pm_pkg::bus_timing_t eeprom_timing,
    input wire logic cfg_valid,
    input wire pci_cfg_pm_pkg::cfg_req_t cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    output logic [7:0] interrupt_line_field
);
    pci_cfg_pm_pkg::bus_timing_t timing;
    logic [7:0] scratch;
    logic [31:0] next_rdata;
    logic next_ack;
    wire hit_int;
    wire hit_scr;
    wire [31:0] sel_cap;
    wire [31:0] sel_int;
    wire [31:0] sel_scr;
    wire [31:0] sel_signature;
    wire [31:0] sel_pm;

    // request decode; a request lives for one mclk cycle only
    wire is_read = cfg_valid && !cfg_req.write;
    wire is_write = cfg_valid && cfg_req.write;
    wire [7:0] req_addr = cfg_req.addr;
    wire [3:0] req_lanes = cfg_req.byte_en;
    wire [31:0] req_data = cfg_req.wdata;

    // only 3ch and 40h take writes; everything else drops them
    wire wr_int = is_write && hit_int; // see RULE_05
    wire wr_scr = is_write && hit_scr; // see RULE_06

    // bus timing bytes, fetched once per hardware reset
    eeprom_capture capture_inst (
        .mclk(mclk),
        .srst(srst),
        .load_valid(eeprom_valid),
        .load_timing(eeprom_timing),
        .timing(timing)
    ); // see RULE_03

    // interrupt line byte in lane 0 of 3ch
    cfg_field_reg #(
        .LANE(`LINE_LANE),
        .RESET_VALUE(`LINE_RESET)
    ) line_reg_inst (
        .mclk(mclk),
        .srst(srst),
        .wr_en(wr_int),
        .byte_en(req_lanes),
        .wdata(req_data),
        .value(interrupt_line_field)
    ); // see RULE_05

    // scratch byte in lane 1 of 40h; soft_rst is kept away from it
    cfg_field_reg #(
        .LANE(`SCRATCH_LANE),
        .RESET_VALUE(`SCRATCH_RESET)
    ) scratch_reg_inst (
        .mclk(mclk),
        .srst(srst),
        .wr_en(wr_scr),
        .byte_en(req_lanes),
        .wdata(req_data),
        .value(scratch)
    ); // see RULE_06

    // timing and interrupt word fields
    wire [7:0] max_latency_value = timing.max_latency_value; // see RULE_01
    wire [7:0] min_grant_value = timing.min_grant_value; // see RULE_02
    wire [7:0] interrupt_pin_field = `INT_PIN_VALUE; // see RULE_04

    // power management capability fields, all fixed
    wire [4:0] wake_state_support = `WAKE_SUPPORT_VALUE; // see RULE_07
    wire state_two_support = `STATE_SUPPORT_VALUE; // see RULE_08
    wire state_one_support = `STATE_SUPPORT_VALUE; // see RULE_08
    wire [2:0] aux_current_field = `AUX_CURRENT_VALUE; // see RULE_09
    wire special_init_flag = `SPECIAL_INIT_VALUE; // see RULE_10
    wire pm_spare_bit = `PM_SPARE_VALUE; // see RULE_17
    wire wake_clock_flag = `WAKE_CLOCK_VALUE; // see RULE_11
    wire [2:0] pm_version_field = `PM_VERSION_VALUE; // see RULE_12
    wire [7:0] next_item_pointer = `NEXT_ITEM_VALUE; // see RULE_13
    wire [7:0] capability_identifier = `CAP_ID_VALUE; // see RULE_14

    // register words; reserved bits are tied to zero
    wire [31:0] cap_word = {
        24'h00_0000,
        `CAP_PTR_VALUE
    }; // see RULE_16

    wire [31:0] timing_word = {
        max_latency_value,
        min_grant_value,
        interrupt_pin_field,
        interrupt_line_field
    };

    wire [31:0] scratch_word = {
        16'h0000,
        scratch,
        8'h00
    }; // see RULE_17

    wire [31:0] signature_word = {
        DEVICE_ID,
        VENDOR_ID
    }; // see RULE_15

    wire [31:0] pm_word = {
        wake_state_support,
        state_two_support,
        state_one_support,
        aux_current_field,
        special_init_flag,
        pm_spare_bit,
        wake_clock_flag,
        pm_version_field,
        next_item_pointer,
        capability_identifier
    };

    // one slot per word; an unmapped offset hits nothing and reads zero
    cfg_word_slot #(
        .OFFSET(`OFS_CAP_PTR)
    ) cap_slot_inst (
        .addr(req_addr),
        .word(cap_word),
        .hit(),
        .sel(sel_cap)
    ); // see RULE_16

    cfg_word_slot #(
        .OFFSET(`OFS_TIMING_INT)
    ) int_slot_inst (
        .addr(req_addr),
        .word(timing_word),
        .hit(hit_int),
        .sel(sel_int)
    );

    cfg_word_slot #(
        .OFFSET(`OFS_SCRATCH)
    ) scratch_slot_inst (
        .addr(req_addr),
        .word(scratch_word),
        .hit(hit_scr),
        .sel(sel_scr)
    );

    cfg_word_slot #(
        .OFFSET(`OFS_SIGNATURE)
    ) signature_slot_inst (
        .addr(req_addr),
        .word(signature_word),
        .hit(),
        .sel(sel_signature)
    ); // see RULE_15

    cfg_word_slot #(
        .OFFSET(`OFS_PM_CAP)
    ) pm_slot_inst (
        .addr(req_addr),
        .word(pm_word),
        .hit(),
        .sel(sel_pm)
    );

    wire [31:0] sel_word = sel_cap | sel_int | sel_scr |
                           sel_signature | sel_pm;

    // writes and idle cycles return zero so the bus never sees stale data
    assign next_rdata = is_read ? sel_word : 32'h0000_0000; // see RULE_17
    assign next_ack = cfg_valid;

    cfg_response response_inst (
        .mclk(mclk),
        .srst(srst),
        .next_ack(next_ack),
        .next_rdata(next_rdata),
        .ack(cfg_ack),
        .rdata(cfg_rdata)
    );

    // soft_rst deliberately unused here: scratch must survive it
    wire unused_ok = soft_rst;
endmodule

// one writable byte of a config word, picked by its byte lane
module cfg_field_reg #(
    parameter int LANE = 0,
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [3:0] byte_en,
    input wire logic [31:0] wdata,
    output logic [7:0] value
);
    // a write with this lane's enable low leaves the byte alone
    wire take = wr_en && byte_en[LANE];
    wire [7:0] lane_data = wdata[LANE*8 +: 8];

    always_ff @(posedge mclk) begin
        if (srst) begin
            value <= RESET_VALUE;
        end else if (take) begin
            value <= lane_data;
        end
    end
endmodule

// bus timing capture from the serial eeprom loader
module eeprom_capture (
    input wire logic mclk,
    input wire logic srst,
    input wire logic load_valid,
    input wire pci_cfg_pm_pkg::bus_timing_t load_timing,
    output pci_cfg_pm_pkg::bus_timing_t timing
);
    logic loaded;

    // only the first valid word after srst counts: a loader that keeps
    // its strobe up must not overwrite the bytes later
    wire take = load_valid && !loaded;

    always_ff @(posedge mclk) begin
        if (srst) begin
            loaded <= 1'h0;
        end else if (take) begin
            loaded <= 1'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            timing <= `TIMING_RESET;
        end else if (take) begin
            timing <= load_timing; // see RULE_03
        end
    end
endmodule

// one register word on the read path, selected by its offset
module cfg_word_slot #(
    parameter logic [7:0] OFFSET = 8'h00
) (
    input wire logic [7:0] addr,
    input wire logic [31:0] word,
    output logic hit,
    output logic [31:0] sel
);
    assign hit = addr == OFFSET;
    assign sel = hit ? word : 32'h0000_0000;
endmodule

// registered answer: ack and read data stand for one cycle
module cfg_response (
    input wire logic mclk,
    input wire logic srst,
    input wire logic next_ack,
    input wire logic [31:0] next_rdata,
    output logic ack,
    output logic [31:0] rdata
);
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack <= 1'h0;
        end else begin
            ack <= next_ack;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

/* File: hw/pci_cfg_pm_cfg.svh */
// offsets, field positions and constant values of the config register bank
`ifndef PCI_CFG_PM_CFG_SVH
`define PCI_CFG_PM_CFG_SVH
`define OFS_CAP_PTR 8'h34
`define OFS_TIMING_INT 8'h3c
`define OFS_SCRATCH 8'h40
`define OFS_SIGNATURE 8'h80
`define OFS_PM_CAP 8'hc0
`define CAP_PTR_VALUE 8'hc0
`define INT_PIN_VALUE 8'h01
`define WAKE_SUPPORT_VALUE 5'h1f
`define AUX_CURRENT_VALUE 3'h2
`define PM_VERSION_VALUE 3'h2
`define NEXT_ITEM_VALUE 8'h00
`define CAP_ID_VALUE 8'h01
`define STATE_SUPPORT_VALUE 1'h1
`define SPECIAL_INIT_VALUE 1'h0
`define PM_SPARE_VALUE 1'h0
`define WAKE_CLOCK_VALUE 1'h0
`define LINE_LANE 0
`define SCRATCH_LANE 1
`define LINE_RESET 8'h00
`define SCRATCH_RESET 8'h00
`define TIMING_RESET 16'h0000
`define TIMING_UNIT_NS 250
`endif

/* File: hw/pci_cfg_pm_pkg.sv */
// types for the configuration register bank
package pci_cfg_pm_pkg;
    typedef struct packed {
        logic [7:0] max_latency_value;
        logic [7:0] min_grant_value;
    } bus_timing_t;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_t;
endpackage

/* File: verification/pci_cfg_props.sv */
// assertions on the config register bank ports
`timescale 1ns/1ps
module pci_cfg_props #(parameter logic [15:0] DEVICE_ID = 0, VENDOR_ID = 0) (
    input wire logic mclk, srst, cfg_valid, cfg_ack,
    input wire pci_cfg_pm_pkg::cfg_req_t cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic [7:0] interrupt_line_field);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire rd = cfg_valid & !cfg_req.write, wr = cfg_valid & cfg_req.write;
    wire [7:0] a = cfg_req.addr, d = cfg_req.wdata[7:0];
    a_ack_pulse: assert property (cfg_valid |=> cfg_ack) else $error("ack");
    a_ack_idle: assert property (!cfg_valid |=> !cfg_ack)
        else $error("ack idle");
    a_write_quiet: assert property (wr |=> cfg_rdata == '0) else $error("wr");
    a_cap_ptr: assert property (rd && a == 8'h34 |=>
        cfg_rdata == 32'h0000_00c0) else $error("cap pointer");
    a_int_pin: assert property (rd && a == 8'h3c |=>
        cfg_rdata[15:0] == {8'h01, $past(interrupt_line_field)})
        else $error("int pin");
    a_signature_word: assert property (rd && a == 8'h80 |=>
        cfg_rdata == {DEVICE_ID, VENDOR_ID}) else $error("signature");
    a_scratch_rsv: assert property (rd && a == 8'h40 |=>
        cfg_rdata[31:16] == '0 && cfg_rdata[7:0] == '0) else $error("scratch");
    a_pm_word: assert property (rd && a == 8'hc0 |=>
        cfg_rdata == 32'hfe82_0001) else $error("pm word");
    a_line_write: assert property (
        wr && a == 8'h3c && cfg_req.byte_en[0] |=>
        interrupt_line_field == $past(d)) else $error("line");
    c_line_write: cover property (wr && a == 8'h3c);
    c_pm_read: cover property (rd && a == 8'hc0);
    c_scratch_read: cover property (rd && a == 8'h40);
endmodule
bind pci_config_pm_capability pci_cfg_props #(.DEVICE_ID(DEVICE_ID),
    .VENDOR_ID(VENDOR_ID)) pci_cfg_props_inst (.mclk, .srst, .cfg_valid,
    .cfg_ack, .cfg_req, .cfg_rdata, .interrupt_line_field);

/* File: verification/eeprom_model.sv */
// eeprom loader: timing bytes a few cycles after each hardware reset
`timescale 1ns/1ps
module eeprom_model #(parameter logic [15:0] T = 16'h1a2b) (
    input wire logic mclk, srst, output logic eeprom_valid,
    output pci_cfg_pm_pkg::bus_timing_t eeprom_timing);
    logic [3:0] n = 0;
    always @(posedge mclk) n <= srst ? 4'h0 : n + {3'h0, n != 4'hf};
    assign eeprom_valid = n > 4'h3;
    // bytes flip later so a late capture shows up as a wrong read
    assign eeprom_timing = n > 4'h6 ? ~T : T;
endmodule

/* File: verification/test_pci_config_pm_capability.sv */
// self-checking bench for the config register bank
`timescale 1ns/1ps
module test_pci_config_pm_capability;
    logic mclk = 0, srst = 1, soft_rst = 0, cfg_valid = 0;
    logic eeprom_valid, cfg_ack;
    logic [7:0] interrupt_line_field;
    logic [31:0] cfg_rdata;
    pci_cfg_pm_pkg::cfg_req_t cfg_req = '0;
    pci_cfg_pm_pkg::bus_timing_t eeprom_timing;
    int n_errors = 0, checked = 0;
    initial forever #5 mclk = ~mclk;
    eeprom_model eeprom_model_inst (
        .mclk(mclk),
        .srst(srst),
        .eeprom_valid(eeprom_valid),
        .eeprom_timing(eeprom_timing)
    );
    pci_config_pm_capability pci_config_pm_capability_inst (
        .mclk(mclk),
        .srst(srst),
        .soft_rst(soft_rst),
        .eeprom_valid(eeprom_valid),
        .eeprom_timing(eeprom_timing),
        .cfg_valid(cfg_valid),
        .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack),
        .interrupt_line_field(interrupt_line_field)
    );
    // one access per call; answer is fixed one cycle later
    task acc(logic w, logic [7:0] a, logic [3:0] be, logic [31:0] d, e);
        @(negedge mclk);
        checked++;
        if (cfg_ack !== 1'b0) begin
            n_errors++;
            $display("[ERR] %0t ack stood over a second cycle", $time);
        end
        {cfg_valid, cfg_req} = {1'b1, w, a, be, d};
        @(negedge mclk);
        cfg_valid = 0;
        checked++;
        if (cfg_ack !== 1'b1 || cfg_rdata !== e) begin
            n_errors++;
            $display("[ERR] %0t addr %h read %h", $time, a, cfg_rdata);
        end
    endtask
    task stop_test;
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task hw_reset;
        srst = 1;
        repeat (8) @(negedge mclk);
        srst = 0;
    endtask
    task t_consts;
        acc(0, 8'h3c, 4'hf, '0, 32'h0000_0100);
        acc(0, 8'h34, 4'hf, '0, 32'h0000_00c0);
        acc(0, 8'h80, 4'hf, '0, 32'h0abc_0def);
        acc(1, 8'hc0, 4'hf, '1, '0);
        acc(0, 8'hc0, 4'hf, '0, 32'hfe82_0001);
        acc(0, 8'h44, 4'hf, '0, '0);
    endtask
    task t_rw;
        acc(1, 8'h3c, 4'he, '1, '0);
        acc(1, 8'h3c, 4'hf, 32'hffff_ff5a, '0);
        checked++;
        if (interrupt_line_field !== 8'h5a) begin
            n_errors++;
            $display("[ERR] %0t line output %h", $time, interrupt_line_field);
        end
        acc(0, 8'h3c, 4'hf, '0, 32'h1a2b_015a);
        acc(1, 8'h40, 4'hf, '1, '0);
        acc(1, 8'h40, 4'hd, 32'h0000_3300, '0);
        soft_rst = 1;
        acc(0, 8'h40, 4'hf, '0, 32'h0000_ff00);
        hw_reset;
        acc(0, 8'h3c, 4'hf, '0, 32'h0000_0100);
        repeat (8) @(negedge mclk);
        acc(0, 8'h3c, 4'hf, '0, 32'h1a2b_0100);
    endtask
    initial begin
        hw_reset;
        t_consts;
        t_rw;
        stop_test;
    end
endmodule
